// *** inc/hsp_defines.vh ***
// Constants for the host serial port, interrupt and general-purpose port block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef HSP_DEFINES_VH
`define HSP_DEFINES_VH

// ----------------------------------------------------------------------------
// Serial addresses (first eight bits of every transfer)
// ----------------------------------------------------------------------------
`define HSP_ADDR_FUNC_WR      8'he8
`define HSP_ADDR_CS_WR        8'he9
`define HSP_ADDR_IRQ_RD       8'hea
`define HSP_ADDR_RATE_RD      8'heb
`define HSP_ADDR_CS_RD        8'hec
`define HSP_ADDR_PC_RD        8'hed

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define HSP_ADDR_BITS         4'h8
`define HSP_DATA_BITS         5'h10
`define HSP_CHIP_LO_BIT       0
`define HSP_CHIP_HI_BIT       1
`define HSP_CMD_LSB           4
`define HSP_CMD_MSB           7
`define HSP_VAL_LSB           8
`define HSP_VAL_MSB           15

// ----------------------------------------------------------------------------
// Command addresses (four-bit index carried in write bits 4 to 7)
// ----------------------------------------------------------------------------
`define HSP_CMD_SYSTEM        4'h0
`define HSP_CMD_IRQ_ENABLE    4'h8
`define HSP_CMD_PORT_OUT      4'ha

// ----------------------------------------------------------------------------
// Fields of the value byte (bit index inside write bits 8 to 15)
// ----------------------------------------------------------------------------
`define HSP_SYS_READ_DIS_BIT  1
`define HSP_SYS_CLR_MODE_BIT  3
`define HSP_PORT_OUT_LSB      4
`define HSP_PORT_OUT_MSB      7

// ----------------------------------------------------------------------------
// Interrupt source bit positions (enable byte and event byte alike)
// ----------------------------------------------------------------------------
`define HSP_SRC_FAULT         0
`define HSP_SRC_PRESENCE      1
`define HSP_SRC_RATE          2
`define HSP_SRC_CS_UPDATE     3
`define HSP_SRC_NON_AUDIO     4
`define HSP_SRC_BURST         5
`define HSP_SRC_SLIP          6
`define HSP_SRC_EMPHASIS      7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HSP_RST_ENABLE        8'h00
`define HSP_RST_PORT_OUT      4'h0
`define HSP_RST_PERIOD        16'h0271

`endif

// *** hdl/hsp_sync.v ***
// Two-stage synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; no bundle coherence is promised.
`timescale 1ns/1ps
`default_nettype none

module hsp_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta_r;

    // ------------------------------------------------------------------------
    // Two flops; only the second stage is read outside
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

// *** hdl/hsp_chg_det.v ***
// Change detector: pulses for one cycle whenever its input word changes.
// Assumes the input is on the same clock; the first sample is only a reference.
`timescale 1ns/1ps
`default_nettype none

module hsp_chg_det #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire         chg
);

    reg [W-1:0] prev_r;
    reg         primed_r;

    // ------------------------------------------------------------------------
    // Previous value; no pulse until a reference has been taken
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r   <= {W{1'b0}};
            primed_r <= 1'b0;
        end else begin
            prev_r   <= d;
            primed_r <= 1'b1;
        end
    end

    assign chg = primed_r && (d != prev_r);

endmodule

`default_nettype wire

// *** hdl/hsp_host_port.v ***
// Host serial port with interrupt pin and four-bit general-purpose port.
// Assumes event sources and the sample tick come from logic on clk;
// serial pins, port pins, direction pin and chip straps are asynchronous.
//
// Operation
// (R1) Interrupt pin idles high, goes low on any enabled event.
// (R2) Mode bit picks fixed low pulse or release on interrupt register read.
// (R3) Enable byte at command 8 gates sources; pin shows their OR.
// (R4) Fault, presence, rate, non-audio and emphasis raise events on change.
// (R5) Channel status refresh of first 48 bits raises an event.
// (R6) Capture of a new burst Pc value raises an event.
// (R7) Slave-mode repeated sample with missing sample raises an event.
// (R8) Fired enabled source latches its state into interrupt read bits 8-15.
// (R9) Fault and non-audio bits read live; others hold latched value.
// (R10) Host keeps oscillator running to get presence and rate events.
// (R11) Clear-on-read mode releases pin once interrupt read address arrives.
// (R12) Pulse mode low time lies between half and one and a half samples.
// (R13) Serial data output is a three-state driver, not open drain.
// (R14) Every transfer opens with an eight-bit serial address selecting function.
// (R15) Host sends address nibbles, chip address, zeros, command, data.
// (R16) Write bits 0 and 1 must match strapped chip address.
// (R17) Data output floats while enable low, drives from enable rise after read.
// (R18) Read-line disable bit keeps data output floating always.
// (R19) Direction pin high makes all port pins inputs, low makes outputs.
// (R20) Command 10 bits 12-15 drive the port pins in output direction.
// (R21) Host sends zeros in bits 8-11 of the port command.
// (R22) In input direction port pin levels read back in bits 0-3 at 0xEB.
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defines.vh"

module hsp_host_port #(
    parameter PW = 16
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       serial_shift_clock,
    input  wire       chip_enable,
    input  wire       serial_in,
    output reg        serial_out,
    output reg        serial_out_oe,
    output reg        irq_n,
    input  wire [1:0] chip_addr_strap,
    input  wire       port_dir_input,
    input  wire [3:0] port_pin_i,
    output reg  [3:0] port_pin_o,
    output reg  [3:0] port_pin_oe,
    input  wire       sample_tick,
    input  wire       receive_fault_pin,
    input  wire       input_presence,
    input  wire [3:0] rate_code,
    input  wire       non_audio_pin,
    input  wire       emphasis_info,
    input  wire       cs_refresh_stb,
    input  wire       burst_pc_stb,
    input  wire       slip_stb
);

    // ------------------------------------------------------------------------
    // Transfer states
    // ------------------------------------------------------------------------
    localparam ST_ADDR = 2'h0;
    localparam ST_DATA = 2'h1;
    localparam ST_SKIP = 2'h2;

    // ------------------------------------------------------------------------
    // Synchronised pins
    // ------------------------------------------------------------------------
    wire [1:0] strap_s;
    wire [3:0] pin_s;
    wire       sck_s;
    wire       ce_s;
    wire       din_s;
    wire       dir_in_s;

    hsp_sync #(.W(4)) u_sync_ctl (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({port_dir_input, serial_in, chip_enable, serial_shift_clock}),
        .q     ({dir_in_s, din_s, ce_s, sck_s})
    );

    hsp_sync #(.W(6)) u_sync_pins (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({chip_addr_strap, port_pin_i}),
        .q     ({strap_s, pin_s})
    );

    // Edge history of the synchronised serial pins
    reg sck_d_r;
    reg ce_d_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_d_r <= 1'b0;
            ce_d_r  <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
            ce_d_r  <= ce_s;
        end
    end

    wire sck_rise = sck_s & ~sck_d_r;
    wire sck_fall = ~sck_s & sck_d_r;
    wire ce_rise  = ce_s & ~ce_d_r;
    wire ce_fall  = ~ce_s & ce_d_r;

    // ------------------------------------------------------------------------
    // Chip address strap, caught once the synchroniser has settled
    // ------------------------------------------------------------------------
    reg [1:0] strap_cnt_r;
    reg [1:0] chip_addr_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_r <= 2'h0;
            chip_addr_r <= 2'h0;
        end else if (strap_cnt_r != 2'h3) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            chip_addr_r <= strap_s;
        end
    end

    // ------------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------------
    reg  [1:0]  state_r;
    reg  [7:0]  addr_sr_r;
    reg  [3:0]  addr_cnt_r;
    reg  [7:0]  addr_r;
    reg  [15:0] wr_sr_r;
    reg  [4:0]  data_cnt_r;
    reg  [15:0] rd_sr_r;

    // Address arrives high nibble first (bit 4 up), then low nibble
    wire [7:0] addr_shifted = {din_s, addr_sr_r[7:1]};
    wire [7:0] addr_word    = {addr_shifted[3:0], addr_shifted[7:4]};
    wire       addr_done    = (state_r == ST_ADDR) && sck_rise && !ce_s
                              && (addr_cnt_r == `HSP_ADDR_BITS - 4'h1);
    wire       is_read      = (addr_r == `HSP_ADDR_IRQ_RD) || (addr_r == `HSP_ADDR_RATE_RD)
                              || (addr_r == `HSP_ADDR_CS_RD) || (addr_r == `HSP_ADDR_PC_RD);
    wire       irq_rd_setup = addr_done && (addr_word == `HSP_ADDR_IRQ_RD);
    wire       frame_end    = (state_r == ST_DATA) && ce_fall;
    wire       wr_commit    = frame_end && (addr_r == `HSP_ADDR_FUNC_WR)
                              && (data_cnt_r == `HSP_DATA_BITS)
                              && (wr_sr_r[`HSP_CHIP_LO_BIT] == chip_addr_r[0])
                              && (wr_sr_r[`HSP_CHIP_HI_BIT] == chip_addr_r[1]);
    wire       irq_rd_done  = frame_end && (addr_r == `HSP_ADDR_IRQ_RD);
    wire [3:0] wr_cmd       = wr_sr_r[`HSP_CMD_MSB:`HSP_CMD_LSB];
    wire [7:0] wr_val       = wr_sr_r[`HSP_VAL_MSB:`HSP_VAL_LSB];

    // Read word chosen at data phase start
    reg  [15:0] rd_word;
    wire [7:0]  irq_data;
    reg  [3:0]  port_in_r;
    always @* begin
        rd_word = 16'h0000;
        case (addr_r)
            `HSP_ADDR_IRQ_RD:  rd_word = {irq_data, 8'h00};   // [R8]
            `HSP_ADDR_RATE_RD: rd_word = {12'h000, port_in_r}; // [R22]
            default:           rd_word = 16'h0000;
        endcase
    end

    // Address phase with enable low, data phase with enable high [R14]
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= ST_ADDR;
            addr_sr_r  <= 8'h00;
            addr_cnt_r <= 4'h0;
            addr_r     <= 8'h00;
            wr_sr_r    <= 16'h0000;
            data_cnt_r <= 5'h00;
            rd_sr_r    <= 16'h0000;
        end else begin
            case (state_r)
                ST_ADDR: begin
                    if (ce_rise) begin
                        // Enable rose before a full address: nothing is ours
                        state_r <= (addr_cnt_r == `HSP_ADDR_BITS) ? ST_DATA : ST_SKIP;
                        data_cnt_r <= 5'h00;
                        rd_sr_r <= rd_word;
                    end else if (sck_rise && addr_cnt_r != `HSP_ADDR_BITS) begin
                        addr_sr_r  <= addr_shifted;
                        addr_cnt_r <= addr_cnt_r + 4'h1;
                        if (addr_done) begin
                            addr_r <= addr_word;
                        end
                    end
                end
                ST_DATA: begin
                    if (ce_fall) begin
                        state_r    <= ST_ADDR;
                        addr_cnt_r <= 4'h0;
                    end else begin
                        // Bits after the sixteenth are dropped
                        if (sck_rise && data_cnt_r != `HSP_DATA_BITS) begin
                            wr_sr_r    <= {din_s, wr_sr_r[15:1]};
                            data_cnt_r <= data_cnt_r + 5'h01;
                        end
                        if (sck_fall) begin
                            rd_sr_r <= {1'b0, rd_sr_r[15:1]};
                        end
                    end
                end
                ST_SKIP: begin
                    if (ce_fall) begin
                        state_r    <= ST_ADDR;
                        addr_cnt_r <= 4'h0;
                    end
                end
                default: begin
                    state_r    <= ST_ADDR;
                    addr_cnt_r <= 4'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Write registers
    // ------------------------------------------------------------------------
    reg [7:0] enable_r;
    reg [3:0] port_out_r;
    reg       clr_mode_r;
    reg       read_dis_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r   <= `HSP_RST_ENABLE;
            port_out_r <= `HSP_RST_PORT_OUT;
            clr_mode_r <= 1'b0;
            read_dis_r <= 1'b0;
        end else if (wr_commit) begin // [R16]
            case (wr_cmd)
                `HSP_CMD_SYSTEM: begin
                    clr_mode_r <= wr_val[`HSP_SYS_CLR_MODE_BIT];
                    read_dis_r <= wr_val[`HSP_SYS_READ_DIS_BIT];
                end
                `HSP_CMD_IRQ_ENABLE: enable_r <= wr_val; // [R3]
                // Low nibble is expected zero and ignored
                `HSP_CMD_PORT_OUT: port_out_r <= wr_val[`HSP_PORT_OUT_MSB:`HSP_PORT_OUT_LSB]; // [R20] [R21]
                default: enable_r <= enable_r;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Serial data output: three-state, only in a read data phase
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out    <= rd_sr_r[0];
            serial_out_oe <= (state_r == ST_DATA) && ce_s && is_read && !read_dis_r; // [R13] [R17] [R18]
        end
    end

    // ------------------------------------------------------------------------
    // General-purpose port
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_pin_o  <= 4'h0;
            port_pin_oe <= 4'h0;
            port_in_r   <= 4'h0;
        end else begin
            port_pin_o  <= port_out_r;
            port_pin_oe <= dir_in_s ? 4'h0 : 4'hf; // [R19]
            if (dir_in_s) begin
                port_in_r <= pin_s;                 // [R22]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------------
    wire [7:0] src_evt;
    wire [4:1] lvl_in = {emphasis_info, non_audio_pin, input_presence, receive_fault_pin};
    wire [4:1] lvl_chg;
    genvar gi;
    generate
        for (gi = 1; gi < 5; gi = gi + 1) begin : g_lvl
            hsp_chg_det #(.W(1)) u_det (
                .clk   (clk),
                .rst_n (rst_n),
                .d     (lvl_in[gi]),
                .chg   (lvl_chg[gi])
            );
        end
    endgenerate

    // Rate code is a word and gets its own detector
    wire rate_chg;
    hsp_chg_det #(.W(4)) u_rate (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (rate_code),
        .chg   (rate_chg)
    );

    // Change-driven and strobe-driven sources [R4] [R5] [R6] [R7]
    assign src_evt[`HSP_SRC_FAULT]     = lvl_chg[1];
    assign src_evt[`HSP_SRC_PRESENCE]  = lvl_chg[2];
    assign src_evt[`HSP_SRC_RATE]      = rate_chg;
    assign src_evt[`HSP_SRC_CS_UPDATE] = cs_refresh_stb;
    assign src_evt[`HSP_SRC_NON_AUDIO] = lvl_chg[3];
    assign src_evt[`HSP_SRC_BURST]     = burst_pc_stb;
    assign src_evt[`HSP_SRC_SLIP]      = slip_stb;
    assign src_evt[`HSP_SRC_EMPHASIS]  = lvl_chg[4];

    wire [7:0] fired = src_evt & enable_r; // [R3]

    // Latched state: presence and emphasis keep their new value, rate and the three strobes a sticky flag.
    // Sticky flags drop at the end of an interrupt read; a new event wins.
    reg [7:0] latch_r;
    reg [7:0] latch_nxt;
    always @* begin
        latch_nxt = irq_rd_done ? (latch_r & 8'h82) : latch_r;
        if (fired[`HSP_SRC_PRESENCE]) latch_nxt[`HSP_SRC_PRESENCE] = input_presence;
        if (fired[`HSP_SRC_EMPHASIS]) latch_nxt[`HSP_SRC_EMPHASIS] = emphasis_info;
        latch_nxt = latch_nxt | (fired & 8'h6c); // [R8]
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r <= 8'h00;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    // Fault and non-audio bits follow the pins at read time [R9]
    assign irq_data = {latch_r[7:5], non_audio_pin, latch_r[3:1], receive_fault_pin};

    // ------------------------------------------------------------------------
    // Sample period measurement, used as the pulse length
    // ------------------------------------------------------------------------
    reg [PW-1:0] per_cnt_r;
    reg [PW-1:0] period_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_r <= {PW{1'b0}};
            period_r  <= `HSP_RST_PERIOD;
        end else if (sample_tick) begin
            per_cnt_r <= {{(PW-1){1'b0}}, 1'b1};
            // A zero-length period would shrink the pulse to a single cycle
            if (per_cnt_r != {PW{1'b0}}) begin
                period_r <= per_cnt_r;
            end
        end else if (per_cnt_r != {PW{1'b1}}) begin
            per_cnt_r <= per_cnt_r + {{(PW-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------------
    reg [PW-1:0] pulse_cnt_r;
    wire         any_fired = |fired;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n       <= 1'b1;         // [R1]
            pulse_cnt_r <= {PW{1'b0}};
        end else if (any_fired) begin
            irq_n       <= 1'b0;         // [R1]
            pulse_cnt_r <= period_r;     // One sample period, inside the allowed window [R12]
        end else if (clr_mode_r) begin
            pulse_cnt_r <= {PW{1'b0}};
            if (irq_rd_setup) begin
                irq_n <= 1'b1;           // [R2] [R11]
            end
        end else if (pulse_cnt_r != {PW{1'b0}}) begin
            pulse_cnt_r <= pulse_cnt_r - {{(PW-1){1'b0}}, 1'b1};
            if (pulse_cnt_r == {{(PW-1){1'b0}}, 1'b1}) begin
                irq_n <= 1'b1;           // [R2] [R12]
            end
        end else begin
            irq_n <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// *** bench/hsp_host_port_monitor.sv ***
// Pin-level checks for the host serial port block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module hsp_host_port_monitor (
    input wire       clk,
    input wire       rst_n,
    input wire       chip_enable,
    input wire       serial_out_oe,
    input wire       irq_n,
    input wire       port_dir_input,
    input wire [3:0] port_pin_o,
    input wire [3:0] port_pin_oe,
    input wire       receive_fault_pin,
    input wire       input_presence,
    input wire [3:0] rate_code,
    input wire       non_audio_pin,
    input wire       emphasis_info,
    input wire       cs_refresh_stb,
    input wire       burst_pc_stb,
    input wire       slip_stb
);
    // ------------
    // Source activity
    // ------------
    reg  [7:0] lvl_r;
    wire [7:0] lvl = {receive_fault_pin, input_presence, rate_code, non_audio_pin, emphasis_info};
    wire       ev  = (lvl != lvl_r) | cs_refresh_stb | burst_pc_stb | slip_stb;
    // Reset to zero only widens ev, so no false failure after reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) lvl_r <= 8'h00;
        else lvl_r <= lvl;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    oe_ce_low_a: assert property ((!chip_enable) [*6] |-> !serial_out_oe) else $error("driver on, enable low");
    oe_rise_a: assert property ($rose(serial_out_oe) |-> chip_enable && $past(chip_enable, 3)) else $error("early drive");
    oe_fall_a: assert property ($fell(serial_out_oe) |-> $past(!chip_enable, 2)) else $error("early drive off");
    dir_in_a: assert property (port_dir_input [*6] |-> port_pin_oe == 4'h0) else $error("port drives as input");
    dir_out_a: assert property ((!port_dir_input) [*6] |-> port_pin_oe == 4'hf) else $error("port not driving");
    dir_same_a: assert property (port_pin_oe inside {4'h0, 4'hf}) else $error("mixed port directions");
    irq_cause_a: assert property ($fell(irq_n) |-> $past(ev)) else $error("irq without source");
    port_commit_a: assert property ($changed(port_pin_o) |-> $past(!chip_enable, 3)) else $error("port changed mid-frame");
    cover property ($fell(irq_n));
    cover property ($rose(serial_out_oe));
    cover property ($changed(port_pin_o));
endmodule
bind hsp_host_port hsp_host_port_monitor u_mon (.clk(clk), .rst_n(rst_n), .chip_enable(chip_enable),
    .serial_out_oe(serial_out_oe), .irq_n(irq_n), .port_dir_input(port_dir_input), .port_pin_o(port_pin_o),
    .port_pin_oe(port_pin_oe), .receive_fault_pin(receive_fault_pin), .input_presence(input_presence),
    .rate_code(rate_code), .non_audio_pin(non_audio_pin), .emphasis_info(emphasis_info),
    .cs_refresh_stb(cs_refresh_stb), .burst_pc_stb(burst_pc_stb), .slip_stb(slip_stb));
`default_nettype wire

// *** bench/hsp_host_model.sv ***
// Host side of the three-wire serial link.
// Assumes the block oversamples the link on clk; shift clock idles low.
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model (
    input  wire logic clk,
    output var  logic sck,
    output var  logic ce,
    output var  logic sin,
    input  wire logic so,
    input  wire logic so_oe
);
    // ------------
    // Bit and frame tasks, 400 ns per link bit
    // ------------
    initial {sck, ce, sin} = 3'h0;
    // Data set while clock low, read just before the clock falls
    task automatic shift(input logic b, output logic r);
        sin <= b;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        r = so_oe ? so : 1'bz;
        @(posedge clk);
        sck <= 1'b0;
    endtask
    // Address upper nibble first, then data bit 0 first
    task automatic frame(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        logic r;
        q = 16'h0000;
        for (int i = 0; i < 8; i++) shift(a[(i + 4) % 8], r);
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            shift(d[i], r);
            q[i] = r;
        end
        repeat (4) @(posedge clk);
        ce  <= 1'b0;
        sin <= ~sin; // No stale level left behind
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** bench/hsp_host_port_tb.sv ***
// Self-checking bench for the host serial port block.
// Assumes the host model owns the serial link; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defines.vh"
module hsp_host_port_tb;
    // ------------
    // Stimulus and checks
    // ------------
    logic        clk, rst_n, sck, ce, sin, so, so_oe, irq_n, dir, tick, rf, pres, na, emp, csr, bst, slp;
    logic [1:0]  strap;
    logic [3:0]  rate, pin_o, pin_oe, ext, tcnt;
    logic [15:0] q;
    wire  [3:0]  pins = (pin_oe & pin_o) | (~pin_oe & ext);
    int          bad_count, n_checks, w;
    hsp_host_port DUT (.clk(clk), .rst_n(rst_n), .serial_shift_clock(sck), .chip_enable(ce),
        .serial_in(sin), .serial_out(so), .serial_out_oe(so_oe), .irq_n(irq_n), .chip_addr_strap(strap),
        .port_dir_input(dir), .port_pin_i(pins), .port_pin_o(pin_o), .port_pin_oe(pin_oe), .sample_tick(tick),
        .receive_fault_pin(rf), .input_presence(pres), .rate_code(rate), .non_audio_pin(na), .emphasis_info(emp),
        .cs_refresh_stb(csr), .burst_pc_stb(bst), .slip_stb(slp));
    hsp_host_model host (.clk(clk), .sck(sck), .ce(ce), .sin(sin), .so(so), .so_oe(so_oe));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Sample period of 16 cycles keeps pulse bounds short
    always @(posedge clk) begin
        tcnt <= tcnt + 4'h1;
        tick <= (tcnt == 4'hf);
    end
    always @(negedge clk) if (irq_n === 1'b0) w++;
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [3:0] c, input logic [7:0] v, input logic [1:0] ca);
        host.frame(`HSP_ADDR_FUNC_WR, {v, c, 2'b00, ca}, q);
    endtask
    task automatic fire(input int k);
        case (k)
            0: rf <= ~rf;
            1: pres <= ~pres;
            2: rate <= rate + 4'h1;
            3: csr <= 1'b1;
            4: na <= ~na;
            5: bst <= 1'b1;
            6: slp <= 1'b1;
            default: emp <= ~emp;
        endcase
        @(posedge clk);
        {csr, bst, slp} <= 3'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #2000000;
        chk(1'b0, "watchdog expired");
        summarize;
    end
    initial begin
        {rst_n, dir, tick, rf, pres, na, emp, csr, bst, slp} = 10'h000;
        {rate, ext, tcnt} = 12'h000;
        strap = 2'b10;
        {bad_count, n_checks, w} = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(irq_n && !so_oe, "idle state");
        wr(`HSP_CMD_SYSTEM, 8'h08, strap);
        fire(3);
        chk(irq_n, "masked fired");
        for (int k = 0; k < 8; k++) begin
            wr(`HSP_CMD_IRQ_ENABLE, 8'h01 << k, strap);
            fire(k);
            chk(!irq_n, "source silent");
            repeat (40) @(posedge clk);
            chk(!irq_n, "early release");
            host.frame(`HSP_ADDR_IRQ_RD, 16'h0000, q);
            chk(q[8 + k], "event bit");
            chk(irq_n, "no release");
        end
        fire(0);
        host.frame(`HSP_ADDR_IRQ_RD, 16'h0000, q);
        chk(q[15:8] === 8'h92, "live and held bits");
        wr(`HSP_CMD_SYSTEM, 8'h00, strap);
        wr(`HSP_CMD_IRQ_ENABLE, 8'h20, strap);
        w = 0;
        fire(5);
        repeat (60) @(posedge clk);
        chk(w >= 8 && w <= 24 && irq_n, "pulse width");
        wr(`HSP_CMD_PORT_OUT, 8'h50, strap);
        chk(pin_o === 4'h5 && pin_oe === 4'hf, "port output");
        wr(`HSP_CMD_PORT_OUT, 8'ha0, ~strap);
        chk(pin_o === 4'h5, "foreign write");
        dir <= 1'b1;
        ext <= 4'h9;
        repeat (8) @(posedge clk);
        chk(pin_oe === 4'h0, "port driving");
        host.frame(`HSP_ADDR_RATE_RD, 16'h0000, q);
        chk(q[3:0] === 4'h9, "port readback");
        wr(`HSP_CMD_SYSTEM, 8'h02, strap);
        host.frame(`HSP_ADDR_IRQ_RD, 16'h0000, q);
        chk(q[0] === 1'bz, "line driven");
        summarize;
    end
endmodule
`default_nettype wire
